// ===== rce_defs.vh
`ifndef RCE_DEFS_VH
`define RCE_DEFS_VH

// error codes
`define RCE_CODE_NONE 8'h00
`define RCE_CODE_FC 8'h01
`define RCE_CODE_ADDR 8'h02
`define RCE_CODE_DATA 8'h03
`define RCE_CODE_NAK 8'h07
`define RCE_CODE_CRC 8'h47
`define RCE_CODE_PARITY 8'h48
`define RCE_CODE_OTHER 8'h49

// crc-16
`define RCE_CRC_PRESET 16'hFFFF
`define RCE_CRC_POLY 16'hA001
`define RCE_MIN_FRAME 8'h04
`define RCE_BCAST_ADDR 8'h00

// error supervision
`define RCE_TX_ERR_LIMIT 4'h8
`define RCE_DISC_MAX_S 6'h3C
`define RCE_TICKS_PER_S 4'hA
`define RCE_ACT_STOP 2'h0
`define RCE_ACT_DLY_STOP 2'h1
`define RCE_ACT_DLY_TRIP 2'h2
`define RCE_ACT_CONT 2'h3

// timing
`define RCE_CLK_HZ 200000000
`define RCE_TICK_MS 100
`define RCE_BAUD 9600
`define RCE_GAP_BITS 33

`endif

// ===== rce_crc16.v
`timescale 1ns/1ps
`default_nettype none
`include "rce_defs.vh"

module rce_crc16
(
   // clock and reset
   input wire sys_clk_i,
   input wire rstn_i,
   // byte stream
   input wire start_i,
   input wire byte_valid_i,
   input wire [7:0] byte_i,
   // running remainder
   output reg [15:0] crc_o
);

   function [15:0] crc_byte;
      input [15:0] crc;
      input [7:0] data;
      integer i;
      reg [15:0] c;
      begin
         c = crc ^ {8'h00, data};
         for (i = 0; i < 8; i = i + 1)
         begin
            if (c[0])
               c = (c >> 1) ^ `RCE_CRC_POLY;
            else
               c = c >> 1;
         end
         crc_byte = c;
      end
   endfunction

   always @(posedge sys_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         crc_o <= `RCE_CRC_PRESET;
      else if (byte_valid_i && start_i)
         crc_o <= crc_byte(`RCE_CRC_PRESET, byte_i); // [R22] [R23]
      else if (byte_valid_i)
         crc_o <= crc_byte(crc_o, byte_i); // [R19] [R20] [R23]
   end

endmodule
`default_nettype wire

// ===== rce_tick.v
`timescale 1ns/1ps
`default_nettype none

module rce_tick
#(
   parameter TICK_CYCLES = 20000000
)
(
   // clock and reset
   input wire sys_clk_i,
   input wire rstn_i,
   // one-cycle enable
   output reg tick_o
);

   reg [31:0] cnt;

   always @(posedge sys_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         cnt <= 32'h0;
         tick_o <= 1'b0;
      end
      else if (cnt >= TICK_CYCLES - 1)
      begin
         cnt <= 32'h0;
         tick_o <= 1'b1;
      end
      else
      begin
         cnt <= cnt + 32'h1;
         tick_o <= 1'b0;
      end
   end

endmodule
`default_nettype wire

// ===== rce_comm_monitor.v
// What this block does
// [R1] logical errors reported as codes 1, 2, 3 and 7
// [R2] logical error in own query answered by error response carrying the code
// [R3] crc mismatch on frame to this station records code 71
// [R4] parity mismatch on a character records code 72
// [R5] framing, overrun or other receive fault records code 73
// [R6] communications error only after eight consecutive transmission errors
// [R7] no response is allowed for a frame with a transmission error
// [R8] any valid frame, to any station, clears the consecutive error count
// [R9] disconnected: running, under bus control, valid seen before, none now
// [R10] disconnection lasting the set time becomes a communications error
// [R11] disconnection time is 0 (off) or 1 to 60 seconds
// [R12] disconnection timer cleared whenever not disconnected
// [R13] latest error code kept readable, overwriting the earlier one
// [R14] action 0: stop drive immediately
// [R15] action 1: stop drive after the error delay
// [R16] action 2: trip if not recovered by delay end, else keep running
// [R17] action 3: keep operating
// [R18] last command and operation data held until recovery
// [R19] sender appends 16-bit crc remainder as last two bytes
// [R20] crc generator is x^16 + x^15 + x^2 + 1
// [R21] receiver recomputes crc; frame accepted only with zero remainder
// [R22] crc register preset to FFFF before first byte
// [R23] per byte: xor into low bits, eight right shifts with A001 feedback
// [R24] frame in progress dropped when character gap reaches 33 bit times
// [R25] intervals timed by a 0.1 s tick from the system clock
// [R26] pulse on start of error action, separate pulse on recovery
`timescale 1ns/1ps
`default_nettype none
`include "rce_defs.vh"

module rce_comm_monitor
#(
   parameter CLK_HZ = `RCE_CLK_HZ,
   parameter BAUD = `RCE_BAUD,
   parameter TICK_MS = `RCE_TICK_MS,
   parameter TICK_CYCLES = (CLK_HZ / 1000) * TICK_MS,
   parameter BIT_CYCLES = (CLK_HZ + BAUD - 1) / BAUD,
   parameter GAP_CYCLES = `RCE_GAP_BITS * BIT_CYCLES
)
(
   // clock and reset
   input wire sys_clk_i,
   input wire rstn_i,
   // received characters
   input wire rx_char_valid_i,
   input wire [7:0] rx_char_i,
   input wire rx_parity_err_i,
   input wire rx_other_err_i,
   input wire rx_frame_end_i,
   input wire [7:0] station_addr_i,
   // logical errors from the parser
   input wire logic_err_valid_i,
   input wire [7:0] logic_err_code_i,
   // drive status
   input wire running_i,
   input wire bus_ctrl_i,
   input wire fault_clear_i,
   // settings
   input wire use_alt_port_i,
   input wire [5:0] disconnect_timeout_setting_i,
   input wire [5:0] disconnect_timeout_setting_alt_port_i,
   input wire [1:0] error_action_select_i,
   input wire [1:0] error_action_select_alt_port_i,
   input wire [9:0] error_action_delay_i,
   input wire [9:0] error_action_delay_alt_port_i,
   // frame results
   output reg frame_ok_o,
   output reg error_response_o,
   output reg [7:0] error_response_code_o,
   output reg [7:0] latest_comm_error_code_o,
   output reg [7:0] latest_comm_error_code_alt_port_o,
   output reg [3:0] tx_err_count_o,
   // supervision
   output reg disconnected_o,
   output reg comm_err_o,
   output reg recover_o,
   output reg hold_cmd_o,
   output reg stop_o,
   output reg trip_o
);

   localparam [4:0] S_IDLE = 5'b00001;
   localparam [4:0] S_DELAY = 5'b00010;
   localparam [4:0] S_CONT = 5'b00100;
   localparam [4:0] S_STOP = 5'b01000;
   localparam [4:0] S_TRIP = 5'b10000;

   wire tick;
   wire [15:0] crc;
   reg in_frame, par_err, oth_err, seen_valid, disc_fired;
   reg [7:0] byte_cnt;
   reg [7:0] frame_addr;
   reg [31:0] gap_cnt;
   reg [9:0] disc_ticks;
   reg [9:0] dly_ticks;
   reg [1:0] act_mode;
   reg [4:0] state;
   reg [4:0] next_state;
   reg ev_valid, ev_txerr, comm_trig, disc_expire;
   reg [7:0] ev_code;
   reg [9:0] disc_limit;
   reg [5:0] disc_set;
   reg [1:0] sel_mode;
   reg [9:0] sel_delay;
   wire addressed;
   wire crc_good;

   rce_tick #(
      .TICK_CYCLES(TICK_CYCLES)
   ) u_tick (
      .sys_clk_i(sys_clk_i),
      .rstn_i(rstn_i),
      .tick_o(tick)
   ); // [R25]

   rce_crc16 u_crc (
      .sys_clk_i(sys_clk_i),
      .rstn_i(rstn_i),
      .start_i(!in_frame),
      .byte_valid_i(rx_char_valid_i),
      .byte_i(rx_char_i),
      .crc_o(crc)
   );

   assign addressed = (frame_addr == station_addr_i) || (frame_addr == `RCE_BCAST_ADDR);
   assign crc_good = (crc == 16'h0000) && (byte_cnt >= `RCE_MIN_FRAME); // [R21]

   // settings of the active port
   always @*
   begin
      disc_set = use_alt_port_i ? disconnect_timeout_setting_alt_port_i
                                : disconnect_timeout_setting_i;
      sel_mode = use_alt_port_i ? error_action_select_alt_port_i : error_action_select_i;
      sel_delay = use_alt_port_i ? error_action_delay_alt_port_i : error_action_delay_i;
      if (disc_set > `RCE_DISC_MAX_S)
         disc_set = `RCE_DISC_MAX_S; // [R11]
      disc_limit = disc_set * `RCE_TICKS_PER_S;
   end

   // frame assembly and gap supervision
   always @(posedge sys_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         in_frame <= 1'b0;
         byte_cnt <= 8'h00;
         frame_addr <= 8'h00;
         par_err <= 1'b0;
         oth_err <= 1'b0;
         gap_cnt <= 32'h0;
      end
      else if (rx_char_valid_i)
      begin
         in_frame <= 1'b1;
         gap_cnt <= 32'h0;
         if (!in_frame)
         begin
            byte_cnt <= 8'h01;
            frame_addr <= rx_char_i;
            par_err <= rx_parity_err_i;
            oth_err <= rx_other_err_i;
         end
         else
         begin
            if (byte_cnt != 8'hFF)
               byte_cnt <= byte_cnt + 8'h01;
            par_err <= par_err | rx_parity_err_i;
            oth_err <= oth_err | rx_other_err_i;
         end
      end
      else if (in_frame && rx_frame_end_i)
         in_frame <= 1'b0;
      else if (in_frame)
      begin
         if (gap_cnt >= GAP_CYCLES - 1)
            in_frame <= 1'b0; // [R24]
         else
            gap_cnt <= gap_cnt + 32'h1;
      end
   end

   // frame verdict at its end
   always @*
   begin
      ev_valid = 1'b0;
      ev_txerr = 1'b0;
      ev_code = `RCE_CODE_NONE;
      if (in_frame && rx_frame_end_i && !rx_char_valid_i)
      begin
         if (par_err)
         begin
            ev_txerr = 1'b1;
            ev_code = `RCE_CODE_PARITY; // [R4]
         end
         else if (oth_err)
         begin
            ev_txerr = 1'b1;
            ev_code = `RCE_CODE_OTHER; // [R5]
         end
         else if (!crc_good && addressed)
         begin
            ev_txerr = 1'b1;
            ev_code = `RCE_CODE_CRC; // [R3]
         end
         else if (crc_good)
            ev_valid = 1'b1;
      end
   end

   // consecutive errors, codes and responses
   always @(posedge sys_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         tx_err_count_o <= 4'h0;
         frame_ok_o <= 1'b0;
         error_response_o <= 1'b0;
         error_response_code_o <= `RCE_CODE_NONE;
         latest_comm_error_code_o <= `RCE_CODE_NONE;
         latest_comm_error_code_alt_port_o <= `RCE_CODE_NONE;
      end
      else
      begin
         frame_ok_o <= ev_valid && addressed; // [R7]
         error_response_o <= 1'b0;
         if (ev_valid)
            tx_err_count_o <= 4'h0; // [R8]
         else if (ev_txerr)
         begin
            if (tx_err_count_o + 4'h1 >= `RCE_TX_ERR_LIMIT)
               tx_err_count_o <= 4'h0;
            else
               tx_err_count_o <= tx_err_count_o + 4'h1;
         end
         if (ev_txerr)
         begin
            if (use_alt_port_i)
               latest_comm_error_code_alt_port_o <= ev_code; // [R13]
            else
               latest_comm_error_code_o <= ev_code; // [R13]
         end
         else if (logic_err_valid_i)
         begin
            error_response_o <= 1'b1; // [R2]
            error_response_code_o <= logic_err_code_i; // [R1]
            if (use_alt_port_i)
               latest_comm_error_code_alt_port_o <= logic_err_code_i;
            else
               latest_comm_error_code_o <= logic_err_code_i;
         end
      end
   end

   // disconnection timer
   always @(posedge sys_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         seen_valid <= 1'b0;
         disc_ticks <= 10'h000;
         disc_fired <= 1'b0;
         disconnected_o <= 1'b0;
      end
      else
      begin
         if (ev_valid)
            seen_valid <= 1'b1;
         disconnected_o <= running_i && bus_ctrl_i && seen_valid && !ev_valid; // [R9]
         if (!disconnected_o || ev_valid)
         begin
            disc_ticks <= 10'h000; // [R12]
            disc_fired <= 1'b0;
         end
         else
         begin
            if (tick && disc_ticks != 10'h3FF)
               disc_ticks <= disc_ticks + 10'h001;
            if (disc_expire)
               disc_fired <= 1'b1;
         end
      end
   end

   always @*
   begin
      disc_expire = disconnected_o && !ev_valid && !disc_fired && (disc_set != 6'h00)
                    && (disc_ticks >= disc_limit); // [R10] [R11]
      comm_trig = disc_expire
                  || (ev_txerr && (tx_err_count_o + 4'h1 >= `RCE_TX_ERR_LIMIT)); // [R6]
   end

   // error action sequencer
   always @*
   begin
      next_state = state;
      case (state)
         S_IDLE:
         begin
            if (comm_trig)
            begin
               case (sel_mode)
                  `RCE_ACT_STOP: next_state = S_STOP; // [R14]
                  `RCE_ACT_CONT: next_state = S_CONT; // [R17]
                  default: next_state = S_DELAY;
               endcase
            end
         end
         S_DELAY:
         begin
            if (ev_valid && act_mode == `RCE_ACT_DLY_TRIP)
               next_state = S_IDLE; // [R16]
            else if (dly_ticks >= sel_delay)
               next_state = (act_mode == `RCE_ACT_DLY_STOP) ? S_STOP : S_TRIP; // [R15] [R16]
         end
         S_CONT:
         begin
            if (ev_valid)
               next_state = S_IDLE;
         end
         S_STOP, S_TRIP:
         begin
            if (fault_clear_i)
               next_state = S_IDLE;
         end
         default: next_state = S_IDLE;
      endcase
   end

   always @(posedge sys_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         state <= S_IDLE;
         act_mode <= `RCE_ACT_STOP;
         dly_ticks <= 10'h000;
         comm_err_o <= 1'b0;
         recover_o <= 1'b0;
         hold_cmd_o <= 1'b0;
         stop_o <= 1'b0;
         trip_o <= 1'b0;
      end
      else
      begin
         state <= next_state;
         comm_err_o <= (state == S_IDLE) && comm_trig; // [R26]
         recover_o <= hold_cmd_o && ev_valid; // [R26]
         if ((state == S_IDLE) && comm_trig)
         begin
            act_mode <= sel_mode;
            dly_ticks <= 10'h000;
            hold_cmd_o <= 1'b1; // [R18]
         end
         else
         begin
            if (ev_valid)
               hold_cmd_o <= 1'b0; // [R18]
            if (state == S_DELAY && tick && dly_ticks != 10'h3FF)
               dly_ticks <= dly_ticks + 10'h001; // [R25]
         end
         stop_o <= (next_state == S_STOP); // [R14] [R15]
         trip_o <= (next_state == S_TRIP); // [R16]
      end
   end

endmodule
`default_nettype wire

// ===== rce_comm_monitor_chk.sv
`timescale 1ns/1ps
`default_nettype none
module rce_comm_monitor_chk (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic rstn_i,
   // inputs
   input wire logic rx_frame_end_i,
   input wire logic logic_err_valid_i,
   input wire logic [7:0] logic_err_code_i,
   input wire logic running_i,
   input wire logic bus_ctrl_i,
   input wire logic use_alt_port_i,
   input wire logic [1:0] error_action_select_i,
   // outputs
   input wire logic frame_ok_o,
   input wire logic error_response_o,
   input wire logic [7:0] error_response_code_o,
   input wire logic [7:0] latest_comm_error_code_o,
   input wire logic [3:0] tx_err_count_o,
   input wire logic disconnected_o,
   input wire logic comm_err_o,
   input wire logic recover_o,
   input wire logic hold_cmd_o,
   input wire logic stop_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!rstn_i);
   chk_ok_after_end: assert property (frame_ok_o |-> $past(rx_frame_end_i) ##1 !frame_ok_o)
      else $error("frame ok out of place");
   chk_ok_clears_count: assert property (frame_ok_o |-> tx_err_count_o == 4'h0)
      else $error("count kept on good frame");
   chk_err_no_reply: assert property (tx_err_count_o > $past(tx_err_count_o) |-> !frame_ok_o)
      else $error("reply after bad frame");
   chk_reply_code: assert property (error_response_o |-> $past(logic_err_valid_i)
      && error_response_code_o == $past(logic_err_code_i)) else $error("bad reply code");
   chk_latest_code: assert property (error_response_o && !use_alt_port_i
      |-> latest_comm_error_code_o == error_response_code_o) else $error("latest code stale");
   chk_comm_cause: assert property (comm_err_o
      |-> $past(disconnected_o) || $past(tx_err_count_o, 2) == 4'h7) else $error("stray error");
   chk_mode0_stop: assert property (comm_err_o && $past(error_action_select_i) == 2'h0 |-> stop_o)
      else $error("no immediate stop");
   chk_hold_pulse: assert property (comm_err_o |-> hold_cmd_o ##1 !comm_err_o)
      else $error("error event wrong");
   chk_recover_hold: assert property (recover_o |-> !hold_cmd_o ##1 !recover_o)
      else $error("recovery event wrong");
   chk_disc_cond: assert property (disconnected_o |-> $past(running_i && bus_ctrl_i))
      else $error("disconnect without cause");
   cover property (comm_err_o && stop_o);
   cover property (recover_o);
   cover property (error_response_o && use_alt_port_i);
endmodule
bind rce_comm_monitor rce_comm_monitor_chk i_rce_comm_monitor_chk (.*);
`default_nettype wire

// ===== rce_host.sv
`timescale 1ns/1ps
`default_nettype none
module rce_host (
   // clock
   input wire logic sys_clk_i,
   // character stream
   output logic char_valid_o,
   output logic [7:0] char_o,
   output logic parity_err_o,
   output logic other_err_o,
   output logic frame_end_o
);
   logic [15:0] crc;
   function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
      c = c ^ {8'h00, b};
      for (int k = 0; k < 8; k++)
         c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
      return c;
   endfunction
   initial
   begin
      char_valid_o = 1'b0;
      char_o = 8'h00;
      parity_err_o = 1'b0;
      other_err_o = 1'b0;
      frame_end_o = 1'b0;
   end
   // fault f: 1 bad crc, 2 parity, 3 framing; gap idle cycles before end
   task send(input logic [47:0] pl, input int n, input int f, input int gap);
      logic [7:0] b;
      crc = 16'hFFFF;
      for (int i = 0; i < n + 2; i++)
      begin
         b = (i < n) ? pl[47 - 8 * i -: 8] : (i == n) ? crc[7:0] ^ {7'h00, f == 1} : crc[15:8];
         if (i < n)
            crc = crc_byte(crc, b);
         char_o = b;
         char_valid_o = 1'b1;
         parity_err_o = f == 2 && i == 1;
         other_err_o = f == 3 && i == 1;
         @(posedge sys_clk_i);
         #1;
      end
      char_valid_o = 1'b0;
      parity_err_o = 1'b0;
      other_err_o = 1'b0;
      char_o = ~b;
      repeat (gap) @(posedge sys_clk_i);
      #1;
      frame_end_o = 1'b1;
      @(posedge sys_clk_i);
      #1;
      frame_end_o = 1'b0;
   endtask
endmodule
`default_nettype wire

// ===== rce_comm_monitor_bench.sv
`timescale 1ns/1ps
`default_nettype none
module rce_comm_monitor_bench;
   logic sys_clk_i, rstn_i, logic_err_valid_i, running_i, bus_ctrl_i, fault_clear_i;
   logic use_alt_port_i;
   logic [7:0] station_addr_i, logic_err_code_i;
   logic [5:0] tmo;
   logic [1:0] act;
   logic [9:0] dly;
   wire logic rx_char_valid_i, rx_parity_err_i, rx_other_err_i, rx_frame_end_i;
   wire logic [7:0] rx_char_i, error_response_code_o;
   wire logic [7:0] latest_comm_error_code_o, latest_comm_error_code_alt_port_o;
   wire logic frame_ok_o, error_response_o, disconnected_o, comm_err_o;
   wire logic recover_o, hold_cmd_o, stop_o, trip_o;
   wire logic [3:0] tx_err_count_o;
   int err_total, n_checks, n_ok, n_err, n_rec, k;
   rce_comm_monitor #(.TICK_CYCLES(20), .BIT_CYCLES(1), .GAP_CYCLES(33)) i_rce_comm_monitor (.*,
      .disconnect_timeout_setting_i(tmo), .disconnect_timeout_setting_alt_port_i(tmo),
      .error_action_select_i(act), .error_action_select_alt_port_i(act),
      .error_action_delay_i(dly), .error_action_delay_alt_port_i(dly));
   rce_host i_rce_host (.sys_clk_i(sys_clk_i), .char_valid_o(rx_char_valid_i), .char_o(rx_char_i),
      .parity_err_o(rx_parity_err_i), .other_err_o(rx_other_err_i), .frame_end_o(rx_frame_end_i));
   initial
   begin
      sys_clk_i = 1'b0;
      forever #2.5 sys_clk_i = ~sys_clk_i;
   end
   // event counters
   always @(posedge sys_clk_i)
   begin
      n_ok <= n_ok + frame_ok_o;
      n_err <= n_err + comm_err_o;
      n_rec <= n_rec + recover_o;
   end
   task chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   task w(input int c);
      repeat (c) @(posedge sys_clk_i);
      #1;
   endtask
   task s4(input logic [31:0] p, input int f);
      i_rce_host.send({p, 16'h0000}, 4, f, 0);
      w(4);
   endtask
   task close_out;
      $display("checks %0d, mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task t_crc;
      k = n_ok;
      i_rce_host.send(48'h050308060001, 6, 0, 0);
      w(4);
      chk(i_rce_host.crc, 16'hEF67);
      chk(n_ok - k, 1);
      s4(32'h0003AA55, 0);
      chk(n_ok - k, 2);
      $display("crc done");
   endtask
   task t_logic;
      logic [7:0] lg [4];
      lg = '{8'h01, 8'h02, 8'h03, 8'h07};
      for (int i = 0; i < 4; i++)
      begin
         use_alt_port_i = i[0];
         logic_err_code_i = lg[i];
         logic_err_valid_i = 1'b1;
         w(1);
         logic_err_valid_i = 1'b0;
         chk(error_response_o, 1);
         chk(error_response_code_o, lg[i]);
         chk(i[0] ? latest_comm_error_code_alt_port_o : latest_comm_error_code_o, lg[i]);
         w(1);
      end
      use_alt_port_i = 1'b0;
      $display("logic done");
   endtask
   task t_tx;
      for (int f = 1; f <= 3; f++)
      begin
         k = n_ok;
         s4(32'h0503AA55, f);
         chk(latest_comm_error_code_o, 8'h46 + f);
         chk(tx_err_count_o, f);
         chk(n_ok - k, 0);
      end
      s4(32'h0903AA55, 0);
      chk(tx_err_count_o, 0);
      k = n_err;
      for (int i = 0; i < 8; i++)
      begin
         chk(n_err - k, 0);
         s4(32'h0503AA55, 1);
      end
      chk(n_err - k, 1);
      chk(stop_o, 0);
      chk(hold_cmd_o, 1);
      k = n_rec;
      s4(32'h0503AA55, 0);
      chk(n_rec - k, 1);
      k = n_ok;
      i_rce_host.send(48'h0503AA550000, 4, 0, 40);
      w(4);
      chk(n_ok - k, 0);
      $display("transmission done");
   endtask
   task t_modes;
      for (int m = 0; m < 3; m++)
      begin
         act = m[1:0];
         k = n_err;
         repeat (8) s4(32'h0503AA55, 1);
         chk(n_err - k, 1);
         chk(stop_o, m == 0);
         w(60);
         chk(stop_o, m < 2);
         chk(trip_o, m == 2);
         fault_clear_i = 1'b1;
         w(1);
         fault_clear_i = 1'b0;
         s4(32'h0503AA55, 0);
         chk(hold_cmd_o, 0);
      end
      $display("modes done");
   endtask
   task t_disc;
      act = 2'h2;
      dly = 10'h005;
      tmo = 6'h01;
      running_i = 1'b1;
      w(5);
      chk(disconnected_o, 0);
      bus_ctrl_i = 1'b1;
      w(3);
      chk(disconnected_o, 1);
      k = n_err;
      w(150);
      chk(n_err - k, 0);
      w(80);
      chk(n_err - k, 1);
      k = n_rec;
      s4(32'h0503AA55, 0);
      chk(n_rec - k, 1);
      tmo = 6'h00;
      k = n_err;
      w(240);
      chk(n_err - k, 0);
      chk(trip_o, 0);
      running_i = 1'b0;
      w(3);
      chk(disconnected_o, 0);
      $display("disconnect done");
   endtask
   initial
   begin
      rstn_i = 1'b0;
      logic_err_valid_i = 1'b0;
      logic_err_code_i = 8'h00;
      running_i = 1'b0;
      bus_ctrl_i = 1'b0;
      fault_clear_i = 1'b0;
      use_alt_port_i = 1'b0;
      station_addr_i = 8'h05;
      act = 2'h3;
      dly = 10'h002;
      tmo = 6'h00;
      repeat (6) @(posedge sys_clk_i);
      #1;
      rstn_i = 1'b1;
      w(1);
      t_crc();
      t_logic();
      t_tx();
      t_modes();
      t_disc();
      close_out();
   end
   // about ten times the expected run
   initial
   begin
      #60000;
      err_total++;
      close_out();
   end
endmodule
`default_nettype wire
